/* rtl/adcr_reg_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adcr_cfg.svh"
module adcr_reg_bank #(
  parameter logic [7:0] PART_ID = 8'h5a, // Arbitrary value
  parameter logic [1:0] SPEED_GRADE = 2'h1
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [`ADCR_AW-1:0] addr_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic lsb_first_o,
  output logic soft_rst_o,
  output logic commit_o,
  output logic [1:0] pdn_mode_o,
  output logic pdn_pin_standby_o,
  output logic dcs_en_o,
  output logic [2:0] test_mode_o,
  output logic pn23_rst_o,
  output logic pn9_rst_o,
  output logic bist_en_o,
  output logic bist_rst_o,
  output logic [1:0] vref_sel_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset image

  localparam adcr_pkg::adcr_setup_t DEFAULTS = '{
    power: `ADCR_R_POWER,
    clock: `ADCR_R_CLOCK,
    test: `ADCR_R_TEST,
    bist: `ADCR_R_BIST,
    vref: `ADCR_R_VREF
  };

  localparam adcr_pkg::adcr_top_state_t RESET_STATE = '{
    master: DEFAULTS,
    lsb_first: 1'b0,
    soft_rst: 1'b0,
    commit: 1'b0,
    rdata: 8'h00,
    rvalid: 1'b0
  };

  adcr_pkg::adcr_top_state_t s_q;
  adcr_pkg::adcr_top_state_t s_d;

  adcr_setup_if setup ();

  adcr_live_bank u_live (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .setup(setup.bank)
  );

  assign setup.commit = s_q.commit;
  assign setup.soft_rst = s_q.soft_rst;
  assign setup.staged = s_q.master;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Unsupported bits keep their fixed value even if the host breaks the zero rule
  function automatic logic [7:0] merge(input logic [7:0] wd, input logic [7:0] mask, input logic [7:0] rst);
    merge = (wd & mask) | (rst & ~mask);
  endfunction

  function automatic logic [7:0] port_image(input logic lsb, input logic srst);
    logic [7:0] v;
    v = `ADCR_R_PORT;
    v[`ADCR_B_LSB_HI] = lsb;
    v[`ADCR_B_LSB_LO] = lsb;
    v[`ADCR_B_SRST_HI] = srst;
    v[`ADCR_B_SRST_LO] = srst;
    port_image = v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [7:0] rd;
    rd = 8'h00;
    s_d = s_q;
    s_d.commit = 1'b0;
    s_d.soft_rst = 1'b0;
    s_d.rvalid = rd_en_i;

    // Readback; staged registers show the master copy, unmapped reads give zero
    unique case (addr_i)
      `ADCR_A_PORT: rd = port_image(s_q.lsb_first, s_q.soft_rst);
      `ADCR_A_ID: rd = PART_ID;
      `ADCR_A_GRADE: rd = {2'b00, SPEED_GRADE, 4'h0};
      `ADCR_A_POWER: rd = s_q.master.power;
      `ADCR_A_CLOCK: rd = s_q.master.clock;
      `ADCR_A_TEST: rd = s_q.master.test;
      `ADCR_A_BIST: rd = s_q.master.bist;
      `ADCR_A_VREF: rd = s_q.master.vref;
      `ADCR_A_XFER: rd = {7'h00, s_q.commit};
      default: rd = 8'h00;
    endcase
    s_d.rdata = rd_en_i ? rd : s_q.rdata;

    if (s_q.soft_rst) begin
      // Soft reset pulse returns everything to defaults and clears itself
      s_d.master = DEFAULTS;
      s_d.lsb_first = 1'b0;
    end else if (wr_en_i) begin
      unique case (addr_i)
        `ADCR_A_PORT: begin
          // Either nibble copy counts, so shift order does not matter
          s_d.lsb_first = wr_data_i[`ADCR_B_LSB_HI] | wr_data_i[`ADCR_B_LSB_LO];
          s_d.soft_rst = wr_data_i[`ADCR_B_SRST_HI] | wr_data_i[`ADCR_B_SRST_LO];
        end
        `ADCR_A_POWER: s_d.master.power = merge(wr_data_i, `ADCR_M_POWER, `ADCR_R_POWER);
        `ADCR_A_CLOCK: s_d.master.clock = merge(wr_data_i, `ADCR_M_CLOCK, `ADCR_R_CLOCK);
        `ADCR_A_TEST: s_d.master.test = merge(wr_data_i, `ADCR_M_TEST, `ADCR_R_TEST);
        `ADCR_A_BIST: s_d.master.bist = merge(wr_data_i, `ADCR_M_BIST, `ADCR_R_BIST);
        `ADCR_A_VREF: s_d.master.vref = merge(wr_data_i, `ADCR_M_VREF, `ADCR_R_VREF);
        // One-cycle pulse; the bit is gone on the next edge without a host write
        `ADCR_A_XFER: s_d.commit = wr_data_i[`ADCR_B_XFER];
        // Read-only, open and feature addresses are ignored on write
        default: s_d.commit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rd_data_o = s_q.rdata;
  assign rd_valid_o = s_q.rvalid;
  assign lsb_first_o = s_q.lsb_first;
  assign soft_rst_o = s_q.soft_rst;
  assign commit_o = s_q.commit;
  assign pdn_mode_o = setup.live.power[1:0];
  assign pdn_pin_standby_o = setup.live.power[5];
  assign dcs_en_o = setup.live.clock[0];
  assign test_mode_o = setup.live.test[2:0];
  assign pn9_rst_o = setup.live.test[4];
  assign pn23_rst_o = setup.live.test[5];
  assign bist_en_o = setup.live.bist[0];
  assign bist_rst_o = setup.live.bist[2];
  assign vref_sel_o = setup.live.vref[7:6];

endmodule // adcr_reg_bank
`default_nettype wire

/* rtl/adcr_cfg.svh */
// Operation
// - Map splits into chip setup, commit byte, converter functions and one feature word.
// - Reference select at 0x18 resets to 0xC0, the 2.0 V p-p setting.
// - Writes to 0x08 through 0x18 stay staged until committed.
// - Writing 0x01 to 0xFF applies all staged values in one cycle.
// - The commit bit clears itself after the update, no host write needed.
// - Any reset, hard or soft, loads every register with its default.
`ifndef ADCR_CFG_SVH
`define ADCR_CFG_SVH

`define ADCR_AW 9
`define ADCR_A_PORT 9'h000
`define ADCR_A_ID 9'h001
`define ADCR_A_GRADE 9'h002
`define ADCR_A_POWER 9'h008
`define ADCR_A_CLOCK 9'h009
`define ADCR_A_TEST 9'h00d
`define ADCR_A_BIST 9'h00e
`define ADCR_A_VREF 9'h018
`define ADCR_A_XFER 9'h0ff
`define ADCR_A_FEAT 9'h100

// Writable bits of each staged register; the rest hold their reset value
`define ADCR_M_POWER 8'h23
`define ADCR_M_CLOCK 8'h01
`define ADCR_M_TEST 8'h37
`define ADCR_M_BIST 8'h05
`define ADCR_M_VREF 8'hc0

`define ADCR_R_PORT 8'h18
`define ADCR_R_POWER 8'h80
`define ADCR_R_CLOCK 8'h01
`define ADCR_R_TEST 8'h00
`define ADCR_R_BIST 8'h04
`define ADCR_R_VREF 8'hc0

// Port setup bit positions, high and low nibble copies, then the commit bit and the grade field LSB
`define ADCR_B_LSB_HI 6
`define ADCR_B_SRST_HI 5
`define ADCR_B_SRST_LO 2
`define ADCR_B_LSB_LO 1
`define ADCR_B_XFER 0
`define ADCR_GRADE_LSB 4

`endif

/* rtl/adcr_pkg.sv */
package adcr_pkg;

  typedef struct packed {
    logic [7:0] power;
    logic [7:0] clock;
    logic [7:0] test;
    logic [7:0] bist;
    logic [7:0] vref;
  } adcr_setup_t;

  typedef struct packed {
    adcr_setup_t master;
    logic lsb_first;
    logic soft_rst;
    logic commit;
    logic [7:0] rdata;
    logic rvalid;
  } adcr_top_state_t;

  typedef struct packed {
    adcr_setup_t live;
  } adcr_bank_state_t;

endpackage

/* rtl/adcr_setup_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface adcr_setup_if;
  logic commit;
  logic soft_rst;
  adcr_pkg::adcr_setup_t staged;
  adcr_pkg::adcr_setup_t live;

  modport bank (input commit, input soft_rst, input staged, output live);
  modport ctrl (output commit, output soft_rst, output staged, input live);
endinterface // adcr_setup_if
`default_nettype wire

/* rtl/adcr_live_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adcr_cfg.svh"
module adcr_live_bank (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  adcr_setup_if.bank setup
);

  localparam adcr_pkg::adcr_setup_t DEFAULTS = '{
    power: `ADCR_R_POWER,
    clock: `ADCR_R_CLOCK,
    test: `ADCR_R_TEST,
    bist: `ADCR_R_BIST,
    vref: `ADCR_R_VREF
  };

  adcr_pkg::adcr_bank_state_t s_q;
  adcr_pkg::adcr_bank_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (setup.soft_rst) begin
      s_d.live = DEFAULTS;
    end else if (setup.commit) begin
      // All five bytes move in the same edge, so no mixed setup is ever seen
      s_d.live = setup.staged;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_q.live <= DEFAULTS;
    end else begin
      s_q <= s_d;
    end
  end

  assign setup.live = s_q.live;

endmodule // adcr_live_bank
`default_nettype wire

/* test/adcr_reg_bank_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module adcr_reg_bank_assertions (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [8:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic lsb_first_o,
  input wire logic soft_rst_o,
  input wire logic commit_o,
  input wire logic [1:0] vref_sel_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  AST_COMMIT: assert property (wr_en_i && addr_i == 9'h0ff && wr_data_i[0] && !soft_rst_o |=> commit_o)
    else $error("commit pulse missing");
  AST_SELF_CLEAR: assert property (commit_o |=> !commit_o)
    else $error("commit bit stuck");
  AST_HOLD: assert property (!commit_o && !soft_rst_o |=> $stable(vref_sel_o))
    else $error("live value moved without commit");
  AST_RESET: assert property (disable iff (1'b0) rst_i |=> vref_sel_o == 2'h3 && !commit_o && !rd_valid_o)
    else $error("reset defaults wrong");
  AST_READ: assert property (rd_en_i |=> rd_valid_o)
    else $error("read answer missing");
  AST_OPEN: assert property (rd_en_i && addr_i == 9'h013 |=> rd_data_o == 8'h00)
    else $error("open address read not zero");
  AST_MIRROR: assert property (rd_en_i && addr_i == 9'h000 |=>
    rd_data_o[6] == rd_data_o[1] && rd_data_o[5] == rd_data_o[2] && rd_data_o[4:3] == 2'h3)
    else $error("port setup nibbles differ");
  AST_SOFT: assert property (wr_en_i && addr_i == 9'h000 && (wr_data_i[5] || wr_data_i[2]) && !soft_rst_o
    |=> soft_rst_o ##1 (!lsb_first_o && vref_sel_o == 2'h3))
    else $error("soft reset failed");
endmodule // adcr_reg_bank_assertions
bind adcr_reg_bank adcr_reg_bank_assertions u_chk (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .wr_en_i(wr_en_i),
  .rd_en_i(rd_en_i),
  .addr_i(addr_i),
  .wr_data_i(wr_data_i),
  .rd_data_o(rd_data_o),
  .rd_valid_o(rd_valid_o),
  .lsb_first_o(lsb_first_o),
  .soft_rst_o(soft_rst_o),
  .commit_o(commit_o),
  .vref_sel_o(vref_sel_o)
);
`default_nettype wire

/* test/adcr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module adcr_host_model (
  input wire logic sys_clk_i,
  input wire logic [7:0] rdat_i,
  output logic wr_o,
  output logic rd_o,
  output logic [8:0] addr_o,
  output logic [7:0] data_o
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 9'h000;
    data_o = 8'h00;
  end
  // Supported bits per byte; zero means a wholly open byte
  function automatic logic [7:0] wmask(input logic [8:0] a);
    case (a)
      9'h000: return 8'h66;
      9'h008: return 8'h23;
      9'h009: return 8'h01;
      9'h00d: return 8'h37;
      9'h00e: return 8'h05;
      9'h018: return 8'hc0;
      9'h0ff: return 8'h01;
      9'h001, 9'h002, 9'h100: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    if (wmask(a) == 8'h00) return;
    @(posedge sys_clk_i);
    #1;
    wr_o = 1'b1;
    addr_o = a;
    data_o = d & wmask(a);
    @(posedge sys_clk_i);
    #1;
    wr_o = 1'b0;
    addr_o = ~a;
    data_o = ~data_o;
  endtask
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    #1;
    rd_o = 1'b1;
    addr_o = a;
    @(posedge sys_clk_i);
    #1;
    d = rdat_i;
    rd_o = 1'b0;
    addr_o = ~a;
  endtask
endmodule // adcr_host_model
`default_nettype wire

/* test/test_adcr_reg_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module test_adcr_reg_bank;
  localparam logic [8:0] SA [5] = '{9'h008, 9'h009, 9'h00d, 9'h00e, 9'h018};
  localparam logic [7:0] MK [5] = '{8'h23, 8'h01, 8'h37, 8'h05, 8'hc0};
  localparam logic [7:0] RV [5] = '{8'h80, 8'h01, 8'h00, 8'h04, 8'hc0};
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  wire logic wr_en_i, rd_en_i, rd_valid_o, lsb_first_o, soft_rst_o, commit_o;
  wire logic pdn_pin_standby_o, dcs_en_o, pn23_rst_o, pn9_rst_o, bist_en_o, bist_rst_o;
  wire logic [8:0] addr_i;
  wire logic [7:0] wr_data_i, rd_data_o;
  wire logic [1:0] pdn_mode_o, vref_sel_o;
  wire logic [2:0] test_mode_o;
  wire logic [15:0] live = {3'h0, pdn_pin_standby_o, pdn_mode_o, dcs_en_o, pn23_rst_o, pn9_rst_o,
    test_mode_o, bist_rst_o, bist_en_o, vref_sel_o};
  int error_cnt = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'hb863_655f;
  logic [7:0] m [5];
  logic [7:0] d;
  logic [15:0] lq;
  always #4 sys_clk_i = ~sys_clk_i;
  // Identity values are arbitrary
  adcr_reg_bank #(.PART_ID(8'ha5), .SPEED_GRADE(2'h2)) DUT (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .lsb_first_o(lsb_first_o),
    .soft_rst_o(soft_rst_o), .commit_o(commit_o), .pdn_mode_o(pdn_mode_o),
    .pdn_pin_standby_o(pdn_pin_standby_o), .dcs_en_o(dcs_en_o), .test_mode_o(test_mode_o),
    .pn23_rst_o(pn23_rst_o), .pn9_rst_o(pn9_rst_o), .bist_en_o(bist_en_o), .bist_rst_o(bist_rst_o),
    .vref_sel_o(vref_sel_o));
  adcr_host_model host (.sys_clk_i(sys_clk_i), .rdat_i(rd_data_o), .wr_o(wr_en_i), .rd_o(rd_en_i),
    .addr_o(addr_i), .data_o(wr_data_i));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] live_exp();
    return {3'h0, m[0][5], m[0][1:0], m[1][0], m[2][5:4], m[2][2:0], m[3][2], m[3][0], m[4][7:6]};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [8:0] a, input logic [7:0] e);
    host.rd(a, d);
    chk("read", {8'h00, e}, {8'h00, d});
    chk("valid", 16'h0001, {15'h0000, rd_valid_o});
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #40000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge sys_clk_i);
    #1 rst_i = 1'b0;
    m = RV;
    chk("live", live_exp(), live);
    for (int i = 0; i < 5; i++) rchk(SA[i], RV[i]);
    rchk(9'h000, 8'h18);
    rchk(9'h002, 8'h20);
    rchk(9'h013, 8'h00);
    rchk(9'h100, 8'h00);
    host.wr(9'h001, 8'h00);
    rchk(9'h001, 8'ha5);
    repeat (4) begin
      lq = live_exp();
      for (int i = 0; i < 5; i++) begin
        seed = lfsr(seed);
        host.wr(SA[i], seed[7:0]);
        m[i] = (RV[i] & ~MK[i]) | (seed[7:0] & MK[i]);
        rchk(SA[i], m[i]);
      end
      chk("staged", lq, live);
      host.wr(9'h0ff, 8'h01);
      chk("commit", 16'h0001, {15'h0000, commit_o});
      @(posedge sys_clk_i);
      #1 chk("applied", live_exp(), live);
      rchk(9'h0ff, 8'h00);
    end
    host.wr(9'h000, 8'h40);
    rchk(9'h000, 8'h5a);
    chk("lsb", 16'h0001, {15'h0000, lsb_first_o});
    // Low nibble copy alone must select the same order
    host.wr(9'h000, 8'h00);
    rchk(9'h000, 8'h18);
    host.wr(9'h000, 8'h02);
    rchk(9'h000, 8'h5a);
    host.wr(9'h000, 8'h04);
    repeat (2) @(posedge sys_clk_i);
    #1 m = RV;
    chk("soft", live_exp(), live);
    rchk(9'h000, 8'h18);
    host.wr(9'h018, 8'h40);
    host.wr(9'h0ff, 8'h01);
    @(posedge sys_clk_i);
    #1 rst_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1 rst_i = 1'b0;
    chk("hard", live_exp(), live);
    rchk(9'h018, 8'hc0);
    // High nibble soft reset copy must clear the order select too
    host.wr(9'h000, 8'h42);
    chk("lsb", 16'h0001, {15'h0000, lsb_first_o});
    host.wr(9'h000, 8'h20);
    repeat (2) @(posedge sys_clk_i);
    #1 chk("soft_hi", 16'h0000, {15'h0000, lsb_first_o});
    report_and_stop();
  end
endmodule // test_adcr_reg_bank
`default_nettype wire
